// ==== hw/dma_mode_irq_addressing.sv ====
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dma_mode_irq_addressing #(
    parameter logic [23:0] PERIPH_BASE = 24'hfff000,
    parameter logic [23:0] PERIPH_MASK = 24'hfff000
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [dma_pkg::CH_N-1:0] TRANSFER_REQ_IN,
    output logic [dma_pkg::CH_N-1:0] TRANSFER_ACK_OUT,
    input wire logic BUS_FAULT_IN,
    input wire logic MEM_READY,
    input wire logic [dma_pkg::DATA_W-1:0] MEM_RDATA,
    output logic [dma_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic [dma_pkg::DATA_W-1:0] MEM_WDATA,
    output logic MEM_WDATA_OE_N,
    output logic MEM_CYC,
    output logic MEM_WE,
    output logic UPPER_BYTE_STROBE,
    output logic LOWER_BYTE_STROBE,
    output logic SPACE_CODE_SELECT,
    output logic SERVICE_IRQ,
    output logic ERROR_IRQ
);
    import dma_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[8*i+:8] = nw[8*i+:8];
            end
        end
        return m;
    endfunction : merge

    function automatic logic [ADDR_W-1:0] step(input logic word, input logic dev16,
                                               input logic device);
        if (word) begin
            return STEP_WORD;
        end else if (device && !dev16) begin
            return STEP_WORD;
        end
        return STEP_BYTE;
    endfunction : step

    function automatic logic bad_addr(input logic [ADDR_W-1:0] a, input logic word);
        return (word && a[0]) || ((a & PERIPH_MASK) == PERIPH_BASE);
    endfunction : bad_addr

    // ==========================================================
    // State
    logic [GCTL_W-1:0] gctl_r;
    logic [CTRL_W-1:0] ctrl_r [CH_N];
    logic [ADDR_W-1:0] mar_r [CH_N];
    logic [ADDR_W-1:0] dar_r [CH_N];
    logic [CNT_W-1:0] cnt_r [CH_N];
    logic [CH_N-1:0] opc_r, err_r, req_s1_r, req_s2_r, req_s3_r, req_r;
    logic [1:0] code_r [CH_N];
    logic berw_r;
    eng_state_e st_r;
    logic [1:0] cur_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic mem_cyc_r, mem_we_r, uds_r, lds_r, oe_n_r, srv_r, erq_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] tmp_r;
    logic [CH_N-1:0] tack_r;

    // ==========================================================
    // Request sampling
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            req_s1_r <= '0;
            req_s2_r <= '0;
            req_s3_r <= '0;
            req_r <= '0;
        end else begin
            req_s1_r <= TRANSFER_REQ_IN;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            req_r <= (req_s2_r & req_s3_r) | (req_r & (req_s2_r | req_s3_r));
        end
    end

    // ==========================================================
    // Request selection and events
    logic [CH_N-1:0] want, irq_allow;
    logic sw0, any, idle, dualp, wordp, ev_cnterr, ev_adrerr, ev_start;
    logic ev_bus_fault_in, ev_done, ev_err, last;
    logic [1:0] pick, ev_ch;

    always_comb begin
        sw0 = ctrl_r[0][C_TRIG] && (ctrl_r[0][C_DUAL] ||
              (ctrl_r[0][C_DEMAND] && ctrl_r[0][C_REPEAT]));
        for (int c = 0; c < CH_N; c++) begin
            want[c] = gctl_r[G_RUN] && ctrl_r[c][C_EN] && !opc_r[c] &&
                      (req_r[c] || (c == 0 && sw0));
            irq_allow[c] = ctrl_r[c][C_IRQ];
        end
        any = |want;
        pick = want[0] ? 2'd0 : (want[1] ? 2'd1 : 2'd2);
        idle = (st_r == S_IDLE);
        dualp = (pick == 2'd0) && ctrl_r[0][C_DUAL];
        wordp = ctrl_r[pick][C_WORD];
        ev_cnterr = idle && any && (cnt_r[pick] == CNT_ZERO);
        ev_adrerr = idle && any && !ev_cnterr && (bad_addr(mar_r[pick], wordp) ||
                    (dualp && bad_addr(dar_r[pick], wordp)));
        ev_start = idle && any && !ev_cnterr && !ev_adrerr;
        ev_bus_fault_in = !idle && mem_cyc_r && BUS_FAULT_IN;
        ev_done = (st_r == S_WR || st_r == S_SGL) && mem_cyc_r && MEM_READY && !BUS_FAULT_IN;
        ev_err = ev_cnterr || ev_adrerr || ev_bus_fault_in;
        ev_ch = idle ? pick : cur_r;
        last = ev_done && (cnt_r[cur_r] == CNT_LAST);
    end

    // ==========================================================
    // Wishbone decode
    logic hit, wr, wr_ok, ch_hit;
    logic [7:0] ch_off;
    logic [1:0] ch_idx;
    logic [3:0] sub;
    logic [31:0] rd_c, state_c;

    always_comb begin
        hit = WB_CYC_I && WB_STB_I && !ack_r;
        wr = hit && WB_WE_I;
        wr_ok = wr && gctl_r[G_UNLOCK];
        ch_hit = (WB_ADR_I >= OFS_CH_BASE) && (WB_ADR_I < OFS_CH_END);
        ch_off = WB_ADR_I - OFS_CH_BASE;
        ch_idx = ch_off[5:4];
        sub = WB_ADR_I[3:0];
        state_c = '0;
        for (int c = 0; c < CH_N; c++) begin
            state_c[ST_OPC+c] = opc_r[c];
            state_c[ST_REQ+c] = want[c];
            state_c[ST_ERR+c] = err_r[c];
            state_c[ST_CODE+2*c+:2] = code_r[c];
        end
        state_c[ST_BERW] = berw_r;
        rd_c = '0;
        if (WB_ADR_I == OFS_GCTL) begin
            rd_c[GCTL_W-1:0] = gctl_r;
        end else if (WB_ADR_I == OFS_CSTATE) begin
            rd_c = state_c;
        end else if (ch_hit) begin
            case (sub)
                SUB_CTRL: rd_c[CTRL_W-1:0] = ctrl_r[ch_idx];
                SUB_MAR: rd_c[ADDR_W-1:0] = mar_r[ch_idx];
                SUB_DAR: rd_c[ADDR_W-1:0] = dar_r[ch_idx];
                SUB_CNT: rd_c[CNT_W-1:0] = cnt_r[ch_idx];
                default: rd_c = '0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= hit;
            dat_r <= hit ? rd_c : '0;
        end
    end

    // ==========================================================
    // Global control
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gctl_r <= GCTL_RST;
        end else if (wr && WB_ADR_I == OFS_GCTL && WB_SEL_I[0]) begin
            gctl_r <= WB_DAT_I[GCTL_W-1:0] & GCTL_MASK;
        end
    end

    // ==========================================================
    // Channel control
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int c = 0; c < CH_N; c++) begin
                ctrl_r[c] <= CTRL_RST;
            end
        end else begin
            for (int c = 0; c < CH_N; c++) begin
                if (wr_ok && ch_hit && ch_idx == c && sub == SUB_CTRL) begin
                    ctrl_r[c] <= CTRL_W'(merge(32'(ctrl_r[c]), WB_DAT_I, WB_SEL_I));
                end
                if ((last && cur_r == c) || (ev_err && ev_ch == c)) begin
                    ctrl_r[c][C_TRIG] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Addresses and counts, not reset
    always_ff @(posedge SYS_CLK) begin
        for (int c = 0; c < CH_N; c++) begin
            if (wr_ok && ch_hit && ch_idx == c) begin
                if (sub == SUB_MAR) begin
                    mar_r[c] <= ADDR_W'(merge(32'(mar_r[c]), WB_DAT_I, WB_SEL_I));
                end
                if (sub == SUB_DAR) begin
                    dar_r[c] <= ADDR_W'(merge(32'(dar_r[c]), WB_DAT_I, WB_SEL_I));
                end
                if (sub == SUB_CNT) begin
                    cnt_r[c] <= CNT_W'(merge(32'(cnt_r[c]), WB_DAT_I, WB_SEL_I));
                end
            end
            if (ev_done && cur_r == c) begin
                mar_r[c] <= mar_r[c] + step(ctrl_r[c][C_WORD], ctrl_r[c][C_DEV16], 1'b0);
                if (c == 0 && ctrl_r[0][C_DUAL]) begin
                    dar_r[c] <= dar_r[c] + step(ctrl_r[c][C_WORD], ctrl_r[c][C_DEV16], 1'b1);
                end
                cnt_r[c] <= cnt_r[c] - CNT_LAST;
            end
        end
    end

    // ==========================================================
    // Channel state flags
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            opc_r <= '0;
            err_r <= '0;
            berw_r <= 1'b0;
            for (int c = 0; c < CH_N; c++) begin
                code_r[c] <= 2'h0;
            end
        end else begin
            for (int c = 0; c < CH_N; c++) begin
                if (wr_ok && ch_hit && ch_idx == c && sub == SUB_CNT) begin
                    opc_r[c] <= 1'b0;
                end
                if (wr_ok && WB_ADR_I == OFS_CSTATE && WB_DAT_I[ST_ERR+c]) begin
                    err_r[c] <= 1'b0;
                    code_r[c] <= 2'h0;
                end
                if (last && cur_r == c) begin
                    opc_r[c] <= 1'b1;
                end
                if (ev_err && ev_ch == c) begin
                    err_r[c] <= 1'b1;
                    code_r[c] <= ev_bus_fault_in ? ERR_BUS : (ev_cnterr ? ERR_CNT : ERR_ADDR);
                end
            end
            if (ev_bus_fault_in && cur_r == 2'd0) begin
                berw_r <= (st_r == S_RD);
            end
        end
    end

    // ==========================================================
    // Interrupt outputs
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            srv_r <= 1'b0;
            erq_r <= 1'b0;
        end else begin
            srv_r <= gctl_r[G_IRQ] && |(opc_r & irq_allow);
            erq_r <= gctl_r[G_IRQ] && |(err_r & irq_allow);
        end
    end

    // ==========================================================
    // Transfer engine
    logic [7:0] lane;
    assign lane = addr_r[0] ? MEM_RDATA[7:0] : MEM_RDATA[15:8];

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r <= S_IDLE;
            cur_r <= 2'd0;
            mem_cyc_r <= 1'b0;
            mem_we_r <= 1'b0;
            uds_r <= 1'b0;
            lds_r <= 1'b0;
            oe_n_r <= 1'b1;
            addr_r <= '0;
            tmp_r <= '0;
            tack_r <= '0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (ev_start) begin
                        cur_r <= pick;
                        addr_r <= mar_r[pick];
                        mem_cyc_r <= 1'b1;
                        uds_r <= wordp || !mar_r[pick][0];
                        lds_r <= wordp || mar_r[pick][0];
                        if (dualp) begin
                            st_r <= S_RD;
                            mem_we_r <= 1'b0;
                        end else begin
                            st_r <= S_SGL;
                            mem_we_r <= !ctrl_r[pick][C_TODEV];
                            tack_r[pick] <= 1'b1;
                        end
                    end
                end
                S_RD: begin
                    if (BUS_FAULT_IN) begin
                        st_r <= S_IDLE;
                        mem_cyc_r <= 1'b0;
                        uds_r <= 1'b0;
                        lds_r <= 1'b0;
                    end else if (MEM_READY) begin
                        st_r <= S_WR;
                        tmp_r <= ctrl_r[0][C_WORD] ? MEM_RDATA : {lane, lane};
                        addr_r <= dar_r[0];
                        mem_we_r <= 1'b1;
                        oe_n_r <= 1'b0;
                        uds_r <= ctrl_r[0][C_WORD] || !dar_r[0][0];
                        lds_r <= ctrl_r[0][C_WORD] || dar_r[0][0];
                    end
                end
                S_WR, S_SGL: begin
                    if (BUS_FAULT_IN || MEM_READY) begin
                        st_r <= S_IDLE;
                        mem_cyc_r <= 1'b0;
                        mem_we_r <= 1'b0;
                        oe_n_r <= 1'b1;
                        uds_r <= 1'b0;
                        lds_r <= 1'b0;
                        tack_r <= '0;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;
    assign TRANSFER_ACK_OUT = tack_r;
    assign MEM_ADDR = addr_r;
    assign MEM_WDATA = tmp_r;
    assign MEM_WDATA_OE_N = oe_n_r;
    assign MEM_CYC = mem_cyc_r;
    assign MEM_WE = mem_we_r;
    assign UPPER_BYTE_STROBE = uds_r;
    assign LOWER_BYTE_STROBE = lds_r;
    assign SPACE_CODE_SELECT = gctl_r[G_SPACE];
    assign SERVICE_IRQ = srv_r;
    assign ERROR_IRQ = erq_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    a_soft_only_ch0: assert property (want[2:1] == (want[2:1] & req_r[2:1]))
        else $error("software request seen on channel 1 or 2");
    a_cont_start: assert property (idle && ctrl_r[0][C_DEMAND] &&
        ctrl_r[0][C_REPEAT] && ctrl_r[0][C_TRIG] && ctrl_r[0][C_EN] && gctl_r[G_RUN] &&
        !opc_r[0] && cnt_r[0] != CNT_ZERO |=> !idle || err_r[0])
        else $error("continuous run did not start");
    a_done_flag: assert property (last |=> opc_r[$past(cur_r)] ##1 (srv_r ||
        !$past(irq_allow[cur_r]) || !$past(gctl_r[G_IRQ])))
        else $error("service end not flagged");
    a_fault_stop: assert property (ev_bus_fault_in |=> idle && !MEM_CYC && err_r[cur_r] &&
        code_r[cur_r] == ERR_BUS)
        else $error("bus fault not handled");
    a_odd_word: assert property (idle && any && !ev_cnterr && wordp && mar_r[pick][0]
        |=> idle && code_r[$past(pick)] == ERR_ADDR)
        else $error("odd word access not refused");
    a_count_err: assert property (ev_cnterr |=> err_r[$past(pick)] &&
        code_r[$past(pick)] == ERR_CNT && !MEM_CYC)
        else $error("count error not raised");
    a_mem_step: assert property (ev_done && !ctrl_r[cur_r][C_WORD] |=>
        mar_r[$past(cur_r)] == $past(mar_r[cur_r]) + STEP_BYTE)
        else $error("memory address step wrong");
    a_lock_write: assert property (wr && !gctl_r[G_UNLOCK] && ch_hit && sub == SUB_CTRL
        && !ev_err && !last |=> ctrl_r[$past(ch_idx)] == $past(ctrl_r[ch_idx]))
        else $error("locked register was written");
    a_global_gate: assert property (!gctl_r[G_RUN] |-> want == '0)
        else $error("request accepted while stopped");
    a_trig_clear: assert property (last && cur_r == 2'd0 |=> !ctrl_r[0][C_TRIG])
        else $error("trigger not cleared at count end");
    a_err_irq: assert property (err_r[0] && irq_allow[0] && gctl_r[G_IRQ] |=> ERROR_IRQ)
        else $error("error interrupt not raised");

    c_dual_done: cover property (st_r == S_RD ##1 st_r == S_WR ##[1:8] ev_done);
    c_single_done: cover property (st_r == S_SGL && ev_done);
    c_count_end: cover property (last);
    c_bus_fault: cover property (ev_bus_fault_in);
endmodule : dma_mode_irq_addressing
`default_nettype wire

// ==== hw/dma_pkg.sv ====
`default_nettype none
package dma_pkg;
    // ==========================================================
    // Widths
    localparam int CH_N = 3;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int CTRL_W = 9;
    localparam int GCTL_W = 8;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_GCTL = 8'h00;
    localparam logic [7:0] OFS_CSTATE = 8'h04;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] OFS_CH_END = 8'h40;
    localparam logic [3:0] SUB_CTRL = 4'h0;
    localparam logic [3:0] SUB_MAR = 4'h4;
    localparam logic [3:0] SUB_DAR = 4'h8;
    localparam logic [3:0] SUB_CNT = 4'hc;
    // ==========================================================
    // Global control fields
    localparam int G_IRQ = 0;
    localparam int G_RUN = 1;
    localparam int G_SPACE = 2;
    localparam int G_UNLOCK = 3;
    localparam logic [GCTL_W-1:0] GCTL_MASK = 8'h0f;
    localparam logic [GCTL_W-1:0] GCTL_RST = 8'h00;
    // ==========================================================
    // Channel control fields
    localparam int C_IRQ = 0;
    localparam int C_EN = 1;
    localparam int C_DUAL = 2;
    localparam int C_WORD = 3;
    localparam int C_DEV16 = 4;
    localparam int C_TODEV = 5;
    localparam int C_DEMAND = 6;
    localparam int C_REPEAT = 7;
    localparam int C_TRIG = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    // ==========================================================
    // Channel state fields and error codes
    localparam int ST_OPC = 0;
    localparam int ST_REQ = 3;
    localparam int ST_ERR = 6;
    localparam int ST_CODE = 9;
    localparam int ST_BERW = 15;
    localparam logic [1:0] ERR_BUS = 2'h1;
    localparam logic [1:0] ERR_ADDR = 2'h2;
    localparam logic [1:0] ERR_CNT = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_LAST = 16'h0001;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
    // ==========================================================
    // Engine states
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SGL = 4'b0010,
        S_RD = 4'b0100,
        S_WR = 4'b1000
    } eng_state_e;
endpackage : dma_pkg
`default_nettype wire

// ==== verification/mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc,
    input wire logic we,
    input wire logic [23:0] addr,
    input wire logic fault_en,
    output logic ready,
    output logic fault,
    output logic [15:0] rdata
);
    logic [1:0] wait_r;
    logic [15:0] noise_r;
    // ==========================================================
    // Answer two cycles into a cycle, with a fault when commanded
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wait_r <= 2'h0;
        else if (cyc && !ready && !fault)
            wait_r <= wait_r + 2'h1;
        else
            wait_r <= 2'h0;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            noise_r <= 16'h0000;
        else
            noise_r <= noise_r + 16'h3c3d;
    end
    assign ready = (wait_r == 2'h2) && !fault_en;
    assign fault = (wait_r == 2'h2) && fault_en;
    // ==========================================================
    // Word-wide data on both lanes; lanes change every cycle when idle
    assign rdata = (cyc && !we) ? (addr[15:0] ^ 16'h5a00) : noise_r;
    // Targets stay outside the controller's own map
endmodule : mem_model
`default_nettype wire

// ==== verification/tb_dma_mode_irq_addressing.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_dma_mode_irq_addressing;
    import dma_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic SYS_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, flt = 1'b0;
    logic [2:0] req = 3'h0;
    logic [31:0] rd, q;
    logic ack, rdy, bf, mcyc, mwe, oen, ub, lb, sp, sirq, eirq;
    logic [2:0] tack;
    logic [23:0] ma, cap_a;
    logic [15:0] md, mr, cap_d;
    logic [5:0] cap_s;
    int fail_count = 0, samples_checked = 0, tick = 0;
    row_s rows [10] = '{'{0, 'h00, 0, 0}, '{0, 'h04, 0, 0}, '{0, 'h10, 0, 0}, '{0, 'h20, 0, 0},
        '{1, 'h10, 'h1ff, 0}, '{0, 'h10, 0, 0}, '{1, 'h00, 'hff, 0}, '{0, 'h00, 0, 'h0f},
        '{1, 'h50, 'h55, 0}, '{0, 'h50, 0, 0}};
    dma_mode_irq_addressing i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WB_ADR_I(adr),
        .WB_DAT_I(dat), .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_DAT_O(rd), .WB_ACK_O(ack), .TRANSFER_REQ_IN(req), .TRANSFER_ACK_OUT(tack),
        .BUS_FAULT_IN(bf), .MEM_READY(rdy), .MEM_RDATA(mr), .MEM_ADDR(ma), .MEM_WDATA(md),
        .MEM_WDATA_OE_N(oen), .MEM_CYC(mcyc), .MEM_WE(mwe), .UPPER_BYTE_STROBE(ub),
        .LOWER_BYTE_STROBE(lb), .SPACE_CODE_SELECT(sp), .SERVICE_IRQ(sirq), .ERROR_IRQ(eirq));
    mem_model i_mem (.clk(SYS_CLK), .rst(SYS_RST), .cyc(mcyc), .we(mwe), .addr(ma),
        .fault_en(flt), .ready(rdy), .fault(bf), .rdata(mr));
    // ==========================================================
    // Clock and timeout
    initial begin
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        tick++;
        if (tick == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ==========================================================
    // Tasks
    task automatic give_verdict();
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        we <= w;
        adr <= a;
        dat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge SYS_CLK); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge SYS_CLK);
    endtask : wb
    task automatic wcyc();
        while (mcyc !== 1'b1) @(posedge SYS_CLK);
        cap_a = ma;
        cap_d = md;
        cap_s = {mwe, tack, ub, lb};
        while (mcyc === 1'b1 && ma === cap_a) @(posedge SYS_CLK);
    endtask : wcyc
    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        chk(32'h1, oen);
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rows[i].e, q);
        end
        chk(32'h1, sp);
        $display("Test registers done");
        wb(1, 8'h24, 32'h101);
        wb(1, 8'h2c, 32'h2);
        wb(1, 8'h20, 32'h3);
        req <= 3'b010;
        wcyc();
        chk(32'h101, cap_a);
        chk(6'b101001, cap_s);
        wcyc();
        chk(32'h102, cap_a);
        repeat (4) @(posedge SYS_CLK);
        chk(32'h1, sirq);
        wb(0, 8'h04, 32'h0);
        chk(32'h2, q & 32'h7);
        repeat (6) @(posedge SYS_CLK);
        chk(32'h0, mcyc);
        req <= 3'b000;
        $display("Test single done");
        wb(1, 8'h3c, 32'h0);
        wb(1, 8'h30, 32'h3);
        req <= 3'b100;
        repeat (8) @(posedge SYS_CLK);
        chk(32'h1, eirq);
        wb(0, 8'h04, 32'h0);
        chk(32'h6100, q & 32'hff00);
        req <= 3'b000;
        repeat (5) @(posedge SYS_CLK);
        wb(1, 8'h04, 32'h1c0);
        wb(1, 8'h24, 32'h103);
        wb(1, 8'h2c, 32'h1);
        wb(1, 8'h20, 32'hb);
        req <= 3'b010;
        repeat (8) @(posedge SYS_CLK);
        wb(0, 8'h04, 32'h0);
        chk(32'h1080, q & 32'h1880);
        req <= 3'b000;
        repeat (5) @(posedge SYS_CLK);
        wb(1, 8'h04, 32'h1c0);
        chk(32'h0, eirq);
        $display("Test errors done");
        wb(1, 8'h14, 32'h201);
        wb(1, 8'h18, 32'h400);
        wb(1, 8'h1c, 32'h1);
        wb(1, 8'h10, 32'h107);
        wcyc();
        chk(32'h201, cap_a);
        chk(6'b000001, cap_s);
        wcyc();
        chk(32'h400, cap_a);
        chk(32'h01, cap_d[15:8]);
        chk(6'b100010, cap_s);
        wb(0, 8'h10, 32'h0);
        chk(32'h7, q);
        wb(1, 8'h14, 32'h300);
        wb(1, 8'h1c, 32'h2);
        wb(1, 8'h10, 32'h1c3);
        wcyc();
        chk(32'h300, cap_a);
        chk(6'b100110, cap_s);
        wcyc();
        chk(32'h301, cap_a);
        wb(0, 8'h10, 32'h0);
        chk(32'hc3, q);
        $display("Test continuous done");
        flt <= 1'b1;
        wb(1, 8'h1c, 32'h1);
        wb(1, 8'h10, 32'h107);
        wcyc();
        wb(0, 8'h04, 32'h0);
        chk(32'h8240, q & 32'h8640);
        chk(32'h1, eirq);
        $display("Test dual done");
        flt <= 1'b0;
        wb(1, 8'h04, 32'h1c0);
        wb(1, 8'h1c, 32'h1);
        wb(1, 8'h10, 32'h107);
        while (mcyc !== 1'b1) @(posedge SYS_CLK);
        SYS_RST <= 1'b1;
        @(posedge SYS_CLK);
        @(posedge SYS_CLK);
        chk(32'h1, {mcyc, oen});
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        wb(0, 8'h10, 32'h0);
        chk(32'h0, q);
        $display("Test reset done");
        give_verdict();
    end
endmodule : tb_dma_mode_irq_addressing
`default_nettype wire
